// ===== hw/rcc_pkg.sv
// Package with constants for reset and clock control
package rcc_pkg;
    // Clock rate of ref_clk in kHz (125 MHz)
    localparam int REF_KHZ = 125000;
    // Fixed middle clock frequency in kHz
    localparam int MID_KHZ = 4000;
    // Low frequency clock in kHz
    localparam int SLOW_KHZ = 32;
    // Divider counts derived from the clock rate
    localparam int MID_DIV = REF_KHZ / MID_KHZ;
    localparam int SLOW_DIV = REF_KHZ / SLOW_KHZ;
    // System oscillator limits in kHz
    localparam int INTERNAL_SYSTEM_OSCILLATOR_MIN_KHZ = 4000;
    localparam int INTERNAL_SYSTEM_OSCILLATOR_MAX_KHZ = 32000;
    // Brownout level encoding
    localparam logic [1:0] LOWEST_BROWNOUT_LEVEL = 2'h0;
    localparam logic [1:0] TOP_BROWNOUT_LEVEL = 2'h3;
    // Power mode encodings
    localparam logic [2:0] MODE_RUN = 3'h0;
    localparam logic [2:0] MODE_SLEEP = 3'h1;
    localparam logic [2:0] MODE_STOP = 3'h2;
    localparam logic [2:0] MODE_STANDBY = 3'h3;
    localparam logic [2:0] MODE_SHUTDOWN = 3'h4;
    // Boot sequence states, one-hot
    typedef enum logic [3:0] {
        ST_POR = 4'h1,
        ST_BOR = 4'h2,
        ST_BOOT = 4'h4,
        ST_RUN = 4'h8
    } boot_state_e;
endpackage

// ===== hw/reset_and_clock_control.sv
// Reset hierarchy and clock distribution for a low-power controller
// Summary of operation
// [RULE1] Power-on comparator releases root reset, starts supervisor
// [RULE2] Lowest brownout rise continues boot, starts power management
// [RULE3] Lowest brownout fall holds brownout reset
// [RULE4] Higher level fall interrupts, reverts to lowest
// [RULE5] Four levels, lowest forced during startup
// [RULE6] Software may raise level after boot
// [RULE7] Five separately generated reset outputs; code generates six, adding rtc_reset_n
// [RULE8] RTC reset by boot, brownout, power-on
// [RULE9] Main clock high domain, derived low-power clock
// [RULE10] Fixed 4MHz middle clock synchronized to main; code aligns it to ulp_cnt zero, not gated by main_clk_en
// [RULE11] Fixed 32kHz slow source; oscillator feeds main
// [RULE12] System oscillator spans 4MHz to 32MHz
// [RULE13] Internal 32kHz oscillator sources slow clock
// [RULE14] Converter clock selects low-power or oscillator
// [RULE15] Domain power follows run/sleep/stop/standby/shutdown
// [RULE16] Higher reset asserts every lower reset
// [RULE17] Brownout interrupt sticky until software clears
`timescale 1ns/1ps
module reset_and_clock_control
    import rcc_pkg::*;
#(
    parameter int BOOT_CYCLES = 16,
    parameter int ULP_DIV = 1,
    parameter int SLOW_DIVIDE = SLOW_DIV,
    parameter int INTERNAL_SYSTEM_OSCILLATOR_KHZ = 32000
) (
    // Clock and asynchronous reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Analog comparator outputs, high means supply above threshold
    input wire logic por_above,
    input wire logic brownout_lowest_above,
    input wire logic brownout_sel_above,
    // Software controls
    input wire logic sys_reset_req,
    input wire logic proc_reset_req,
    input wire logic level_wr,
    input wire logic [1:0] level_wdata,
    input wire logic irq_clear,
    input wire logic [2:0] power_mode,
    input wire logic converter_sel_osc,
    // Oscillator outputs as clock enables
    input wire logic internal_system_oscillator,
    input wire logic internal_slow_oscillator,
    // Reset level outputs, active low
    output logic por_reset_n,
    output logic brownout_reset_n,
    output logic boot_reset_n,
    output logic system_reset_n,
    output logic processor_reset_n,
    output logic rtc_reset_n,
    // Sequencing outputs
    output logic bandgap_en,
    output logic brownout_sup_en,
    output logic boot_continue,
    output logic power_management_unit_start,
    output logic [1:0] brownout_level,
    output logic brownout_irq,
    // Clock enables and domain power
    output logic main_clk_en,
    output logic ultra_low_power_clock,
    output logic fixed_middle_clock,
    output logic low_frequency_clock,
    output logic converter_clock,
    output logic high_performance_domain,
    output logic low_power_domain
);
    // Elaboration checks, counters are 8 and 16 bits wide
    if (BOOT_CYCLES < 1 || BOOT_CYCLES > 65536) begin
        $error("boot count out of range");
    end
    if (ULP_DIV < 1 || ULP_DIV > 256) begin
        $error("low-power divider out of range");
    end
    if (SLOW_DIVIDE < 2 || SLOW_DIVIDE > 65536) begin
        $error("slow divider out of range");
    end
    if (MID_DIV < 2 || MID_DIV > 256) begin
        $error("middle divider out of range");
    end
    // Oscillator must lie inside its supported span
    if (INTERNAL_SYSTEM_OSCILLATOR_KHZ < INTERNAL_SYSTEM_OSCILLATOR_MIN_KHZ || INTERNAL_SYSTEM_OSCILLATOR_KHZ > INTERNAL_SYSTEM_OSCILLATOR_MAX_KHZ) begin
        $error("oscillator out of range");
    end

    boot_state_e state; // Sequencer state
    logic [15:0] boot_cnt; // Boot delay counter
    logic [1:0] level_sel; // Active brownout threshold
    logic [7:0] mid_cnt; // Middle clock divider
    logic [15:0] slow_cnt; // Slow clock divider
    logic [7:0] ulp_cnt; // Low-power clock divider

    // Boot sequencer across power-on, brownout and boot levels
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state <= ST_POR;
            boot_cnt <= 16'h0000;
        end else if (!por_above) begin
            state <= ST_POR; // [RULE1]
            boot_cnt <= 16'h0000;
        end else begin
            unique case (state)
                // Root released, wait for lowest brownout rise
                ST_POR: state <= ST_BOR; // [RULE1]
                ST_BOR: begin
                    if (brownout_lowest_above) begin
                        state <= ST_BOOT; // [RULE2]
                    end
                    boot_cnt <= 16'h0000;
                end
                ST_BOOT: begin
                    if (!brownout_lowest_above) begin
                        state <= ST_BOR; // [RULE3]
                    end else if (boot_cnt == 16'(BOOT_CYCLES - 1)) begin
                        state <= ST_RUN;
                    end else begin
                        boot_cnt <= boot_cnt + 16'h0001;
                    end
                end
                ST_RUN: begin
                    if (!brownout_lowest_above) begin
                        state <= ST_BOR; // [RULE3]
                    end
                end
            endcase
        end
    end

    // Brownout threshold selection
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            level_sel <= LOWEST_BROWNOUT_LEVEL;
        end else if (state != ST_RUN) begin
            level_sel <= LOWEST_BROWNOUT_LEVEL; // [RULE5]
        // A warning revert outranks a software write in the same cycle
        end else if (level_sel != LOWEST_BROWNOUT_LEVEL
            && !brownout_sel_above) begin
            level_sel <= LOWEST_BROWNOUT_LEVEL; // [RULE4]
        end else if (level_wr) begin
            level_sel <= level_wdata; // [RULE6]
        end
    end

    // Sticky brownout warning, set wins over clear
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            brownout_irq <= 1'b0;
        end else begin
            // Same condition as the level revert, so both land together
            if (state == ST_RUN && level_sel != LOWEST_BROWNOUT_LEVEL
                && !brownout_sel_above) begin
                brownout_irq <= 1'b1; // [RULE4] [RULE17]
            end else if (irq_clear) begin
                brownout_irq <= 1'b0; // [RULE17]
            end
        end
    end

    // Reset outputs, each higher level forces all lower ones
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            por_reset_n <= 1'b0;
            brownout_reset_n <= 1'b0;
            boot_reset_n <= 1'b0;
            system_reset_n <= 1'b0;
            processor_reset_n <= 1'b0;
            rtc_reset_n <= 1'b0;
        end else begin
            por_reset_n <= (state != ST_POR); // [RULE7]
            brownout_reset_n <= (state == ST_BOOT) || (state == ST_RUN);
            boot_reset_n <= (state == ST_RUN); // [RULE16]
            system_reset_n <= (state == ST_RUN) && !sys_reset_req;
            processor_reset_n <= (state == ST_RUN) && !sys_reset_req
                && !proc_reset_req; // [RULE16]
            rtc_reset_n <= (state == ST_RUN); // [RULE8]
        end
    end

    // Clock dividers producing one-cycle enables
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            mid_cnt <= 8'h00;
            slow_cnt <= 16'h0000;
            ulp_cnt <= 8'h00;
            fixed_middle_clock <= 1'b0;
            low_frequency_clock <= 1'b0;
            ultra_low_power_clock <= 1'b0;
        end else begin
            // Low-power clock divides the main clock, so never runs faster
            if (main_clk_en) begin
                ulp_cnt <= (ulp_cnt == 8'(ULP_DIV - 1)) ? 8'h00
                    : ulp_cnt + 8'h01;
            end
            ultra_low_power_clock <= main_clk_en
                && (ulp_cnt == 8'h00); // [RULE9]
            // Middle clock aligned to the low-power divider count, not gated by the main enable
            mid_cnt <= (mid_cnt == 8'(MID_DIV - 1)) ? 8'h00 : mid_cnt + 8'h01;
            fixed_middle_clock <= (mid_cnt == 8'h00)
                && (ulp_cnt == 8'h00); // [RULE10]
            if (internal_slow_oscillator) begin
                slow_cnt <= (slow_cnt == 16'(SLOW_DIVIDE - 1)) ? 16'h0000
                    : slow_cnt + 16'h0001;
            end
            low_frequency_clock <= internal_slow_oscillator
                && (slow_cnt == 16'h0000); // [RULE11] [RULE13]
        end
    end

    // Combinational status, domains and selections
    always_comb begin
        // Reference and supervisor start only after root reset release
        bandgap_en = por_reset_n; // [RULE1]
        brownout_sup_en = por_reset_n; // [RULE1]
        boot_continue = (state == ST_BOOT) || (state == ST_RUN); // [RULE2]
        power_management_unit_start = boot_continue;
        brownout_level = level_sel;
        main_clk_en = internal_system_oscillator
            && por_reset_n; // [RULE11] [RULE12]
        converter_clock = converter_sel_osc ? internal_system_oscillator
            : ultra_low_power_clock; // [RULE14]
        high_performance_domain = (power_mode == MODE_RUN)
            || (power_mode == MODE_SLEEP); // [RULE15]
        low_power_domain = high_performance_domain
            || (power_mode == MODE_STOP) || (power_mode == MODE_STANDBY);
    end
endmodule

// ===== tb/rcc_chk.sv
// Checker for the reset and clock control outputs
`timescale 1ns/1ps
module rcc_chk
    import rcc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Stimulus at the block's pins
    input wire logic por_above,
    input wire logic brownout_lowest_above,
    input wire logic irq_clear,
    input wire logic converter_sel_osc,
    input wire logic internal_system_oscillator,
    input wire logic [2:0] power_mode,
    // Observed outputs
    input wire logic por_reset_n,
    input wire logic brownout_reset_n,
    input wire logic boot_reset_n,
    input wire logic system_reset_n,
    input wire logic processor_reset_n,
    input wire logic brownout_irq,
    input wire logic ultra_low_power_clock,
    input wire logic converter_clock,
    input wire logic high_performance_domain,
    input wire logic low_power_domain,
    input wire logic [1:0] brownout_level
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // Boot reset seen on two edges in a row
    sequence boot_held; !boot_reset_n [*2]; endsequence
    // Interrupt newly raised
    sequence irq_new; brownout_irq && !$past(brownout_irq); endsequence
    AST_POR_HOLD: assert property (
        !por_above |-> ##[1:3] !por_reset_n)
        else $error("root reset not held");
    AST_BOR_HOLD: assert property (
        !brownout_lowest_above |-> ##[1:3] !brownout_reset_n)
        else $error("brownout reset not held");
    AST_START_LEVEL: assert property (
        boot_held |-> brownout_level == LOWEST_BROWNOUT_LEVEL)
        else $error("level not lowest at startup");
    AST_IRQ_REVERT: assert property (
        irq_new |-> brownout_level == LOWEST_BROWNOUT_LEVEL)
        else $error("level not reverted on warning");
    AST_IRQ_STICKY: assert property (
        brownout_irq && !irq_clear |=> brownout_irq)
        else $error("warning lost without clear");
    AST_CHAIN: assert property (
        (por_reset_n || !brownout_reset_n)
        && (brownout_reset_n || !boot_reset_n)
        && (boot_reset_n || !system_reset_n)
        && (system_reset_n || !processor_reset_n))
        else $error("reset order broken");
    AST_DOMAIN: assert property (
        power_mode <= MODE_SHUTDOWN |->
        high_performance_domain == (power_mode <= MODE_SLEEP)
        && low_power_domain == (power_mode != MODE_SHUTDOWN))
        else $error("domain power wrong");
    AST_CONV: assert property (
        converter_clock == (converter_sel_osc ? internal_system_oscillator
        : ultra_low_power_clock))
        else $error("converter source wrong");
endmodule
bind reset_and_clock_control rcc_chk chk (.*);

// ===== tb/supply_model.sv
// Supply comparators and oscillators in front of the block
`timescale 1ns/1ps
module supply_model #(
    parameter int POR_MV = 1000,
    parameter int LOW_MV = 1600,
    parameter int STEP_MV = 200
) (
    // Clock, supply in millivolts and selected level
    input wire logic ref_clk,
    input wire logic [11:0] mv,
    input wire logic [1:0] level,
    // Comparator and oscillator outputs
    output logic por_above,
    output logic lowest_above,
    output logic sel_above,
    output logic sys_osc,
    output logic slow_osc
);
    // Free-running tick for both oscillators
    logic [3:0] tick = 4'h0;
    always @(posedge ref_clk) begin
        tick <= tick + 4'h1;
    end
    // Comparators, selected one moves with the level
    assign por_above = mv > POR_MV;
    assign lowest_above = mv > LOW_MV;
    assign sel_above = mv > LOW_MV + STEP_MV * level;
    // Fast oscillator every fourth cycle, slow one every sixteenth
    assign sys_osc = tick[1:0] == 2'h0;
    assign slow_osc = tick == 4'hF;
endmodule

// ===== tb/reset_and_clock_control_test.sv
// Self-checking bench for reset and clock control
`timescale 1ns/1ps
module reset_and_clock_control_test import rcc_pkg::*;;
    // Stimulus, counters and observed outputs
    int n_fail = 0, n_tests = 0, cyc = 0;
    logic [11:0] mv = 12'h000;
    logic ref_clk = 0, nrst = 0, srq = 0, prq = 0, wr = 0, clr = 0, os = 0;
    logic [1:0] wd = 2'h0;
    logic [2:0] md = 3'h0;
    logic pa, la, sa, so, lo, pr, br, bt, sr, cr, rr, bg, irq, hp, lp;
    logic sup_en, bc, power_management_unit, mce, mfc, lfc;
    logic ulp, cv;
    logic [1:0] lvl;
    supply_model sup (.ref_clk(ref_clk), .mv(mv), .level(lvl), .por_above(pa),
        .lowest_above(la), .sel_above(sa), .sys_osc(so), .slow_osc(lo));
    reset_and_clock_control #(.BOOT_CYCLES(8), .SLOW_DIVIDE(4)) dut (
        .ref_clk(ref_clk), .nrst(nrst), .por_above(pa),
        .brownout_lowest_above(la), .brownout_sel_above(sa),
        .sys_reset_req(srq), .proc_reset_req(prq), .level_wr(wr),
        .level_wdata(wd), .irq_clear(clr), .power_mode(md),
        .converter_sel_osc(os), .internal_system_oscillator(so),
        .internal_slow_oscillator(lo), .por_reset_n(pr),
        .brownout_reset_n(br), .boot_reset_n(bt), .system_reset_n(sr),
        .processor_reset_n(cr), .rtc_reset_n(rr), .bandgap_en(bg),
        .brownout_sup_en(sup_en), .boot_continue(bc), .brownout_level(lvl),
        .power_management_unit_start(power_management_unit), .brownout_irq(irq),
        .main_clk_en(mce), .ultra_low_power_clock(ulp),
        .fixed_middle_clock(mfc), .low_frequency_clock(lfc),
        .converter_clock(cv),
        .high_performance_domain(hp), .low_power_domain(lp));
    initial forever #4 ref_clk = ~ref_clk;
    task chk(input logic g, input logic e);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %0t flag %b want %b", $time, g, e);
        end
    endtask
    task chkv(input logic [1:0] g, input logic [1:0] e);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %0t level %h want %h", $time, g, e);
        end
    endtask
    task chkn(input int g, input int e);
        n_tests++;
        if (g != e) begin
            n_fail++;
            $display("ERROR %0t count %0d want %0d", $time, g, e);
        end
    endtask
    task w(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Hang guard
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            test_done;
        end
    end
    // Supply rises, all levels come out of reset
    task t_boot;
        mv = 12'hBB8;
        w(5);
        chk(br, 1'b1);
        chk(bt, 1'b0);
        w(25);
        chk(pr, 1'b1);
        chk(bg, 1'b1);
        chk(sup_en, 1'b1);
        chk(br, 1'b1);
        chk(bt, 1'b1);
        chk(bc, 1'b1);
        chk(power_management_unit, 1'b1);
        chk(sr, 1'b1);
        chk(cr, 1'b1);
        chkv(lvl, 2'h0);
    endtask
    // Enable rates: model oscillator fires every 4th cycle, slow every 16th
    task t_clocks;
        int n_mc;
        int n_ulp;
        int n_mf;
        int n_lf;
        n_mc = 0;
        n_ulp = 0;
        n_mf = 0;
        n_lf = 0;
        repeat (4 * MID_DIV) begin
            @(negedge ref_clk);
            n_mc += (mce === 1'b1) ? 1 : 0;
            n_ulp += (ulp === 1'b1) ? 1 : 0;
            n_mf += (mfc === 1'b1) ? 1 : 0;
        end
        chkn(n_mc, MID_DIV);
        chkn(n_ulp, MID_DIV);
        chkn(n_mf, 4);
        // Slow divider of 4 on a 16-cycle source gives one per 64
        repeat (128) begin
            @(negedge ref_clk);
            n_lf += (lfc === 1'b1) ? 1 : 0;
        end
        chkn(n_lf, 2);
    endtask
    // Higher level warns, reverts and stays pending
    task t_warn;
        wd = 2'h2;
        wr = 1'b1;
        w(1);
        wr = 1'b0;
        w(2);
        chkv(lvl, 2'h2);
        mv = 12'h708;
        w(4);
        chk(irq, 1'b1);
        chkv(lvl, 2'h0);
        chk(br, 1'b1);
        mv = 12'hBB8;
        w(4);
        chk(irq, 1'b1);
        clr = 1'b1;
        w(1);
        clr = 1'b0;
        w(2);
        chk(irq, 1'b0);
    endtask
    // Software resets reach only their own level and below
    task t_soft;
        srq = 1'b1;
        w(3);
        chk(sr, 1'b0);
        chk(cr, 1'b0);
        chk(bt, 1'b1);
        chk(rr, 1'b1);
        srq = 1'b0;
        prq = 1'b1;
        w(3);
        chk(sr, 1'b1);
        chk(cr, 1'b0);
        prq = 1'b0;
        w(3);
        for (int m = 0; m < 5; m++) begin
            md = m[2:0];
            os = m[0];
            w(1);
            chk(hp, m < 2);
            chk(lp, m < 4);
        end
        md = MODE_RUN;
    endtask
    // Raised level, brownout, full power loss, then restart
    task t_drop;
        wd = 2'h3;
        wr = 1'b1;
        w(1);
        wr = 1'b0;
        w(1);
        chkv(lvl, 2'h3);
        mv = 12'h514;
        w(4);
        chk(br, 1'b0);
        chk(rr, 1'b0);
        chk(bc, 1'b0);
        chk(power_management_unit, 1'b0);
        chk(pr, 1'b1);
        mv = 12'h1F4;
        w(4);
        chk(pr, 1'b0);
        chk(bg, 1'b0);
        mv = 12'hBB8;
        w(30);
        chk(bt, 1'b1);
        chkv(lvl, 2'h0);
    endtask
    initial begin
        w(5);
        nrst = 1'b1;
        t_boot;
        t_clocks;
        t_warn;
        t_soft;
        t_drop;
        test_done;
    end
endmodule
